//--- src/ccr_cfg.svh
// Offsets, reset values and decode constants
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// ============================================================
// Register offsets
`define CCR_OFS_PRE_TERM       8'h03
`define CCR_OFS_VOLTAGE        8'h04
`define CCR_OFS_TERM_TIMER     8'h05
`define CCR_OFS_IR_THERMAL     8'h06

// ============================================================
// Register reset values
`define CCR_RST_PRE_TERM       8'h11
`define CCR_RST_VOLTAGE        8'h9a
`define CCR_RST_TERM_TIMER     8'h9a
`define CCR_RST_IR_THERMAL     8'h03
`define CCR_RDATA_UNMAPPED     8'h00

// ============================================================
// Current codes, in mA
`define CCR_CUR_OFFSET_MA      12'd128
`define CCR_CUR_STEP_MA        12'd128
`define CCR_IND_EARLY_MA       12'd800
`define CCR_RST_CUR_MA         12'd256

// ============================================================
// Voltage codes, in mV
`define CCR_VOLT_OFFSET_MV     13'd3504
`define CCR_VOLT_STEP_MV       13'd16
`define CCR_VOLT_MAX_CODE      6'h38
`define CCR_RECHG_LOW_MV       13'd100
`define CCR_RECHG_HIGH_MV      13'd300
`define CCR_RST_VOLT_MV        13'd4112
`define CCR_RST_RECHG_MV       13'd4012

// ============================================================
// Timers
`define CCR_WDOG_40_S          8'd40
`define CCR_WDOG_80_S          8'd80
`define CCR_WDOG_160_S         8'd160
`define CCR_TMR_5_H            5'd5
`define CCR_TMR_8_H            5'd8
`define CCR_TMR_12_H           5'd12
`define CCR_TMR_20_H           5'd20

// ============================================================
// IR compensation and thermal
`define CCR_IR_STEP_MOHM       7'd10
`define CCR_CLAMP_STEP_MV      7'd16
`define CCR_TEMP_OFFSET_C      7'd60
`define CCR_TEMP_STEP_C        7'd20
`define CCR_RST_TEMP_C         7'd120

`endif

//--- src/ccr_pkg.sv
// Types shared by the charger configuration register bank
package ccr_pkg;
  typedef logic [7:0] ccr_byte_t;
  typedef logic [1:0] ccr_idx_t;
endpackage

//--- src/ccr_config_regs.sv
// Charger configuration register bank with decoded field outputs
// Function
// - Precharge code: 128mA offset plus 128mA per LSB, reset 0001.
// - Termination code: 128mA offset plus 128mA per LSB, reset 0001.
// - Voltage code: 3504mV plus 16mV per step, max 111000, reset 100110.
// - Restart margin bit: 100mV below target clear, 300mV set, reset clear.
// - Termination enable bit allows termination when set, resets set.
// - Indicator threshold bit set: indicator at 800mA, else termination.
// - Watchdog field: 00 off, 01 40s, 10 80s, 11 160s, reset 01.
// - Safety timer runs when enabled; 5/8/12/20 hours, reset 8 hours.
// - Resistance 10 mohm per step, clamp 16mV per step, reset zero.
// - Die temperature limit 60/80/100/120 C, reset 120 C.
// - All bits including reserved read back as written, no side effect.
`timescale 1ns/1ps
`include "ccr_cfg.svh"

module ccr_config_regs (
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire ccr_pkg::ccr_byte_t reg_wdata_in,
  input  wire logic              reg_rd_in,
  output ccr_pkg::ccr_byte_t     reg_rdata_out,
  output logic                   reg_rvalid_out,
  output logic [3:0]             precharge_current_code_out,
  output logic [3:0]             end_of_charge_current_code_out,
  output logic [5:0]             target_battery_voltage_code_out,
  output logic                   low_battery_threshold_select_out,
  output logic                   restart_margin_select_out,
  output logic                   term_enable_out,
  output logic                   indicator_early_out,
  output logic [1:0]             watchdog_code_out,
  output logic                   safety_timer_run_out,
  output logic [1:0]             fast_phase_duration_code_out,
  output logic [2:0]             path_resistance_code_out,
  output logic [2:0]             compensation_ceiling_code_out,
  output logic [1:0]             die_temp_limit_code_out,
  output logic [11:0]            precharge_ma_out,
  output logic [11:0]            term_ma_out,
  output logic [11:0]            indicator_ma_out,
  output logic [12:0]            target_mv_out,
  output logic [12:0]            restart_mv_out,
  output logic                   watchdog_enable_out,
  output logic [7:0]             watchdog_s_out,
  output logic [4:0]             fast_phase_h_out,
  output logic [6:0]             path_mohm_out,
  output logic [6:0]             ceiling_mv_out,
  output logic [6:0]             die_temp_c_out
);
  import ccr_pkg::*;

  // ============================================================
  // Register array
  localparam ccr_byte_t REG_OFS [4] = '{`CCR_OFS_PRE_TERM,
    `CCR_OFS_VOLTAGE, `CCR_OFS_TERM_TIMER, `CCR_OFS_IR_THERMAL};
  localparam ccr_byte_t REG_RST [4] = '{`CCR_RST_PRE_TERM,
    `CCR_RST_VOLTAGE, `CCR_RST_TERM_TIMER, `CCR_RST_IR_THERMAL};

  ccr_byte_t regs_ff [4];
  logic      hit;
  ccr_idx_t  hit_idx;

  always_comb begin
    hit     = 1'b0;
    hit_idx = 2'd0;
    for (int k = 0; k < 4; k++) begin
      if (reg_addr_in == REG_OFS[k]) begin
        hit     = 1'b1;
        hit_idx = ccr_idx_t'(k);
      end
    end
  end

  // Reserved bits are stored like any other bit
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_reg
      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          regs_ff[gi] <= REG_RST[gi];
        end else if (reg_wr_in && reg_addr_in == REG_OFS[gi]) begin
          regs_ff[gi] <= reg_wdata_in;
        end
      end
    end
  endgenerate

  // ============================================================
  // Read port
  ccr_byte_t nxt_rdata;
  logic      rvalid_ff;
  ccr_byte_t rdata_ff;

  // Read is pure: no field changes as a result of it
  assign nxt_rdata = hit ? regs_ff[hit_idx] : `CCR_RDATA_UNMAPPED;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdata_ff  <= `CCR_RDATA_UNMAPPED;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign reg_rdata_out  = rdata_ff;
  assign reg_rvalid_out = rvalid_ff;

  // ============================================================
  // Raw fields
  assign precharge_current_code_out       = regs_ff[0][7:4];
  assign end_of_charge_current_code_out   = regs_ff[0][3:0];
  assign target_battery_voltage_code_out  = regs_ff[1][7:2];
  assign low_battery_threshold_select_out = regs_ff[1][1];
  assign restart_margin_select_out        = regs_ff[1][0];
  assign term_enable_out                  = regs_ff[2][7];
  assign indicator_early_out              = regs_ff[2][6];
  assign watchdog_code_out                = regs_ff[2][5:4];
  assign safety_timer_run_out             = regs_ff[2][3];
  assign fast_phase_duration_code_out     = regs_ff[2][2:1];
  assign path_resistance_code_out         = regs_ff[3][7:5];
  assign compensation_ceiling_code_out    = regs_ff[3][4:2];
  assign die_temp_limit_code_out          = regs_ff[3][1:0];

  // ============================================================
  // Decoded values, one cycle behind the fields
  logic [5:0]  vcode_eff;
  logic [11:0] nxt_term_ma;
  logic [12:0] nxt_target_mv;
  logic [7:0]  nxt_wdog_s;
  logic [4:0]  nxt_hours;

  // Codes above the top step are stored but regulate at the top step
  assign vcode_eff = (regs_ff[1][7:2] > `CCR_VOLT_MAX_CODE) ?
                     `CCR_VOLT_MAX_CODE : regs_ff[1][7:2];
  assign nxt_term_ma = `CCR_CUR_OFFSET_MA +
                       12'(regs_ff[0][3:0]) * `CCR_CUR_STEP_MA;
  assign nxt_target_mv = `CCR_VOLT_OFFSET_MV +
                         13'(vcode_eff) * `CCR_VOLT_STEP_MV;

  always_comb begin
    case (regs_ff[2][5:4])
      2'h1:    nxt_wdog_s = `CCR_WDOG_40_S;
      2'h2:    nxt_wdog_s = `CCR_WDOG_80_S;
      2'h3:    nxt_wdog_s = `CCR_WDOG_160_S;
      default: nxt_wdog_s = 8'h00;
    endcase
    case (regs_ff[2][2:1])
      2'h0:    nxt_hours = `CCR_TMR_5_H;
      2'h1:    nxt_hours = `CCR_TMR_8_H;
      2'h2:    nxt_hours = `CCR_TMR_12_H;
      default: nxt_hours = `CCR_TMR_20_H;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      precharge_ma_out    <= `CCR_RST_CUR_MA;
      term_ma_out         <= `CCR_RST_CUR_MA;
      indicator_ma_out    <= `CCR_RST_CUR_MA;
      target_mv_out       <= `CCR_RST_VOLT_MV;
      restart_mv_out      <= `CCR_RST_RECHG_MV;
      watchdog_enable_out <= 1'b1;
      watchdog_s_out      <= `CCR_WDOG_40_S;
      fast_phase_h_out    <= `CCR_TMR_8_H;
      path_mohm_out       <= 7'h00;
      ceiling_mv_out      <= 7'h00;
      die_temp_c_out      <= `CCR_RST_TEMP_C;
    end else begin
      precharge_ma_out <= `CCR_CUR_OFFSET_MA +
                          12'(regs_ff[0][7:4]) * `CCR_CUR_STEP_MA;
      term_ma_out      <= nxt_term_ma;
      indicator_ma_out <= regs_ff[2][6] ? `CCR_IND_EARLY_MA
                                        : nxt_term_ma;
      target_mv_out    <= nxt_target_mv;
      restart_mv_out   <= nxt_target_mv - (regs_ff[1][0] ?
                          `CCR_RECHG_HIGH_MV : `CCR_RECHG_LOW_MV);
      watchdog_enable_out <= (regs_ff[2][5:4] != 2'h0);
      watchdog_s_out   <= nxt_wdog_s;
      fast_phase_h_out <= nxt_hours;
      path_mohm_out    <= 7'(regs_ff[3][7:5]) * `CCR_IR_STEP_MOHM;
      ceiling_mv_out   <= 7'(regs_ff[3][4:2]) * `CCR_CLAMP_STEP_MV;
      die_temp_c_out   <= `CCR_TEMP_OFFSET_C +
                          7'(regs_ff[3][1:0]) * `CCR_TEMP_STEP_C;
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  chk_pre_decode: assert property (
    precharge_ma_out == 12'd128 + 12'($past(regs_ff[0][7:4])) * 12'd128)
    else $error("precharge current decode wrong");
  chk_term_decode: assert property (
    term_ma_out == 12'd128 + 12'($past(regs_ff[0][3:0])) * 12'd128)
    else $error("termination current decode wrong");
  chk_volt_clamp: assert property (
    target_mv_out >= 13'd3504 && target_mv_out <= 13'd4400)
    else $error("target voltage out of range");
  chk_restart_margin: assert property (
    target_mv_out - restart_mv_out ==
    ($past(regs_ff[1][0]) ? 13'd300 : 13'd100))
    else $error("restart margin wrong");
  chk_term_enable: assert property (
    reg_wr_in && reg_addr_in == 8'h05 |=> term_enable_out ==
    $past(reg_wdata_in[7]))
    else $error("termination enable not updated");
  chk_indicator_sel: assert property (
    ##1 (indicator_ma_out == ($past(regs_ff[2][6]) ? 12'd800 : term_ma_out)))
    else $error("indicator threshold wrong");
  chk_wdog_period: assert property (
    watchdog_enable_out |-> watchdog_s_out ==
    (8'd20 << $past(regs_ff[2][5:4])))
    else $error("watchdog period wrong");
  chk_timer_hours: assert property (
    $past(regs_ff[2][2:1]) == 2'h1 |-> fast_phase_h_out == 5'd8)
    else $error("safety timer duration wrong");
  chk_ir_clamp: assert property (
    path_mohm_out <= 7'd70 && ceiling_mv_out <= 7'd112 &&
    ceiling_mv_out[3:0] == 4'h0)
    else $error("IR compensation decode wrong");
  chk_temp_limit: assert property (
    die_temp_c_out == 7'd60 + 7'($past(regs_ff[3][1:0])) * 7'd20)
    else $error("die temperature decode wrong");
  chk_write_read: assert property (
    reg_wr_in && hit ##1 reg_rd_in && !reg_wr_in &&
    reg_addr_in == $past(reg_addr_in) |=>
    reg_rdata_out == $past(reg_wdata_in, 2) && reg_rvalid_out)
    else $error("read does not return written value");
  chk_read_pure: assert property (
    reg_rd_in && !reg_wr_in |=> $stable(regs_ff[0]) && $stable(regs_ff[1])
    && $stable(regs_ff[2]) && $stable(regs_ff[3]))
    else $error("read changed a register");

  cov_write_read: cover property (reg_wr_in && hit ##1 reg_rd_in);
  cov_unmapped: cover property (reg_rd_in && !hit);
  cov_volt_over: cover property (regs_ff[1][7:2] > 6'h38);
  cov_early_ind: cover property (indicator_early_out && term_enable_out);

endmodule // ccr_config_regs

//--- tb/ccr_host_model.sv
// Host model that drives the register byte port
`timescale 1ns/1ps

module ccr_host_model (
  input  wire logic       clock_in,
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic       reg_rvalid_in,
  output logic [7:0]      reg_addr_out,
  output logic            reg_wr_out,
  output logic [7:0]      reg_wdata_out,
  output logic            reg_rd_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out = 1'b0;
  end

  // ============================================================
  // Bus cycles; idle bus shows the inverted address, and inverted data only after a write
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge clock_in);
    #1;
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clock_in);
    #1;
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge clock_in);
    #1;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    d = reg_rdata_in;
    v = reg_rvalid_in;
  endtask

  // Write, then read the same byte on the very next edge
  task automatic wr_rd(input logic [7:0] a, d, output logic [7:0] q,
                       output logic v);
    @(posedge clock_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge clock_in);
    #1;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b1;
    @(posedge clock_in);
    #1;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
    q = reg_rdata_in;
    v = reg_rvalid_in;
  endtask

  // ============================================================
  // Field update keeps neighbours; reserved bit of 0x05 goes out zero
  task automatic rmw(input logic [7:0] a, m, f);
    logic [7:0] d;
    logic       v;
    rd(a, d, v);
    wr(a, ((d & ~m) | (f & m)) & ((a == 8'h05) ? 8'hfe : 8'hff));
  endtask
endmodule // ccr_host_model

//--- tb/charger_config_registers_tb.sv
// Self-checking bench for the charger configuration register bank
`timescale 1ns/1ps

module charger_config_registers_tb;
  import ccr_pkg::*;
  logic             clock_in = 1'b0;
  logic             rst_in = 1'b1;
  logic [7:0]       addr, sh [3:6];
  ccr_byte_t        wdata, rdata;
  logic             wr, rd, rvalid;
  wire logic [30:0] raw;
  wire logic [96:0] dv;
  int               error_cnt = 0;
  int               n_compared = 0;
  int               cyc = 0;

  always #5 clock_in = ~clock_in;

  ccr_config_regs u_ccr_config_regs (
    .clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .precharge_current_code_out(raw[30:27]),
    .end_of_charge_current_code_out(raw[26:23]),
    .target_battery_voltage_code_out(raw[22:17]),
    .low_battery_threshold_select_out(raw[16]),
    .restart_margin_select_out(raw[15]), .term_enable_out(raw[14]),
    .indicator_early_out(raw[13]), .watchdog_code_out(raw[12:11]),
    .safety_timer_run_out(raw[10]),
    .fast_phase_duration_code_out(raw[9:8]),
    .path_resistance_code_out(raw[7:5]),
    .compensation_ceiling_code_out(raw[4:2]),
    .die_temp_limit_code_out(raw[1:0]),
    .precharge_ma_out(dv[96:85]), .term_ma_out(dv[84:73]),
    .indicator_ma_out(dv[72:61]), .target_mv_out(dv[60:48]),
    .restart_mv_out(dv[47:35]), .watchdog_enable_out(dv[34]),
    .watchdog_s_out(dv[33:26]), .fast_phase_h_out(dv[25:21]),
    .path_mohm_out(dv[20:14]), .ceiling_mv_out(dv[13:7]),
    .die_temp_c_out(dv[6:0])
  );

  ccr_host_model u_ccr_host_model (
    .clock_in(clock_in), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
    .reg_addr_out(addr), .reg_wr_out(wr), .reg_wdata_out(wdata),
    .reg_rd_out(rd)
  );

  // ============================================================
  // Expected decode; voltage clamps at the highest legal code
  function automatic logic [96:0] dec(input logic [7:0] r3, r4, r5, r6);
    logic [5:0]  vc;
    logic [12:0] t;
    logic [11:0] tm;
    logic [4:0]  fh;
    vc = (r4[7:2] > 6'h38) ? 6'h38 : r4[7:2];
    t = 13'h0db0 + 13'h0010 * vc;
    tm = 12'h080 + 12'h080 * r3[3:0];
    fh = r5[2] ? (r5[1] ? 5'h14 : 5'h0c) : (r5[1] ? 5'h08 : 5'h05);
    return {12'h080 + 12'h080 * r3[7:4], tm, r5[6] ? 12'h320 : tm, t,
            t - (r4[0] ? 13'h012c : 13'h0064), |r5[5:4],
            (r5[5:4] == 2'h0) ? 8'h00 : 8'h14 << r5[5:4], fh,
            7'h0a * r6[7:5], 7'h10 * r6[4:2], 7'h3c + 7'h14 * r6[1:0]};
  endfunction

  task automatic chk(input string nm, input logic [96:0] e, g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ============================================================
  // Fields now, decode a cycle later, then read back
  task automatic look(input logic [7:0] a);
    logic [7:0]  q;
    logic        v;
    logic [96:0] e;
    chk("fields", {sh[3], sh[4], sh[5][7:1], sh[6]}, raw);
    @(posedge clock_in);
    #1;
    e = dec(sh[3], sh[4], sh[5], sh[6]);
    chk("decode", e, dv);
    u_ccr_host_model.rd(a, q, v);
    chk("rdata", (a >= 8'h03 && a <= 8'h06) ? sh[a] : 8'h00, q);
    chk("rvalid", 1'b1, v);
    @(posedge clock_in);
    #1;
    chk("rvalid pulse end", 1'b0, rvalid);
  endtask

  task automatic step(input logic [7:0] a, d);
    u_ccr_host_model.wr(a, d);
    if (a >= 8'h03 && a <= 8'h06) sh[a] = d;
    look(a);
  endtask

  logic [15:0] cor [7] = '{16'h04e0, 16'h04fd, 16'h05ff, 16'h03ff,
                           16'h06ff, 16'h0300, 16'h07a5};

  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    void'($urandom(61083));
    sh[3] = 8'h11;
    sh[4] = 8'h9a;
    sh[5] = 8'h9a;
    sh[6] = 8'h03;
    repeat (5) @(posedge clock_in);
    #1;
    rst_in = 1'b0;
    for (int a = 2; a < 8; a++) look(8'(a));
    foreach (cor[i]) step(cor[i][15:8], cor[i][7:0]);
    for (int k = 0; k < 4; k++) begin
      step(8'h05, 8'(k * 8'h12));
      step(8'h06, 8'(k * 8'h25));
    end
    repeat (60) step(8'h02 + 8'($urandom % 6), 8'($urandom));
    u_ccr_host_model.rmw(8'h05, 8'h30, 8'h20);
    sh[5] = (sh[5] & 8'hce) | 8'h20;
    look(8'h05);
    // Back-to-back write and read of every mapped register
    for (int a = 3; a < 7; a++) begin
      logic [7:0] d, q;
      logic       v;
      d = 8'($urandom);
      u_ccr_host_model.wr_rd(8'(a), d, q, v);
      sh[a] = d;
      chk("write then read", d, q);
      chk("rvalid", 1'b1, v);
      look(8'(a));
    end
    // Reset in mid-run must override written values
    rst_in = 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    rst_in = 1'b0;
    chk("reset read port", 9'h000, {rvalid, rdata});
    sh = '{8'h11, 8'h9a, 8'h9a, 8'h03};
    look(8'h04);
    conclude();
  end
endmodule // charger_config_registers_tb
